/* include/asfifo_regs.vh */
// Purpose: constants for the stream fifo
// Assumes: single clock, plain Verilog-2005
// Notes:   depths are in words
`ifndef ASFIFO_REGS_VH
`define ASFIFO_REGS_VH
`define ASFIFO_DEPTH_MIN    16
`define ASFIFO_DEPTH_MAX    131072
`define ASFIFO_DEPTH_DEF    16
`define ASFIFO_IMPL_BRAM    0
`define ASFIFO_IMPL_DIST    1
`define ASFIFO_BRAM_EXTRA   0
`define ASFIFO_CLK_HZ       20000000
`endif

/* logic/asfifo_mem.v */
// Purpose: simple dual-port word memory with registered read data
// Assumes: one clock; write and read may hit the same address
// Notes:   read data come out of a register
module asfifo_mem #(
  parameter AW = 4,
  parameter DW = 8
) (
  input  wire          clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_q
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

/* logic/asfifo_top.v */
// Purpose: single-clock stream fifo with sideband fields and occupancy count
// Assumes: sys_clk at 20 MHz; upstream and downstream on the same clock
// Notes:   memory read is registered; an output stage holds the head word
`include "asfifo_regs.vh"
module asfifo_top #(
  parameter DEPTH      = `ASFIFO_DEPTH_DEF,
  parameter IMPL       = `ASFIFO_IMPL_BRAM,
  parameter DATA_BYTES = 1,
  parameter DEST_W     = 1,
  parameter ID_W       = 1,
  parameter USER_W     = 1,
  parameter HAS_ARESETN = 1,
  parameter HAS_COUNT  = 1
) (
  input  wire                      sys_clk,
  input  wire                      rst_n,
  input  wire                      aresetn,
  input  wire                      s_tvalid,
  output reg                       s_tready,
  input  wire [DATA_BYTES*8-1:0]   s_tdata,
  input  wire [DATA_BYTES-1:0]     s_tstrb,
  input  wire [DATA_BYTES-1:0]     s_tkeep,
  input  wire                      s_tlast,
  input  wire [DEST_W-1:0]         s_tdest,
  input  wire [ID_W-1:0]           s_tid,
  input  wire [USER_W-1:0]         s_tuser,
  output reg                       m_tvalid,
  input  wire                      m_tready,
  output reg  [DATA_BYTES*8-1:0]   m_tdata,
  output reg  [DATA_BYTES-1:0]     m_tstrb,
  output reg  [DATA_BYTES-1:0]     m_tkeep,
  output reg                       m_tlast,
  output reg  [DEST_W-1:0]         m_tdest,
  output reg  [ID_W-1:0]           m_tid,
  output reg  [USER_W-1:0]         m_tuser,
  output reg  [clog2(DEPTH):0]     data_count
);
  function integer clog2;
    input integer v;
    integer i;
    begin
      clog2 = 0;
      for (i = v - 1; i > 0; i = i >> 1) begin
        clog2 = clog2 + 1;
      end
    end
  endfunction

  // storage geometry; memory rounds up to a power of two of at least 16 words
  localparam AW           = (clog2(DEPTH) < 4) ? 4 : clog2(DEPTH);
  localparam MEM_WORDS    = 1 << AW;
  // realised capacity adds the output stage to the memory
  localparam ACTUAL_DEPTH = MEM_WORDS + 1 + ((IMPL == `ASFIFO_IMPL_BRAM) ? `ASFIFO_BRAM_EXTRA : 0);
  localparam CW           = clog2(DEPTH) + 1;
  localparam DW           = DATA_BYTES * 8;

  // one lane holds a data byte, its strobe bit and its keep bit
  localparam LANE_W       = 10;
  localparam POS_USER     = 0;
  localparam POS_ID       = POS_USER + USER_W;
  localparam POS_DEST     = POS_ID + ID_W;
  localparam POS_LAST     = POS_DEST + DEST_W;
  localparam POS_LANES    = POS_LAST + 1;
  localparam WW           = POS_LANES + DATA_BYTES * LANE_W;

  localparam [AW:0]   FULL_LEVEL = {1'b1, {AW{1'b0}}};
  localparam [AW:0]   PTR_ONE    = {{AW{1'b0}}, 1'b1};
  localparam [AW+1:0] OCC_ONE    = {{(AW+1){1'b0}}, 1'b1};

  // words between two pointers; the extra pointer bit tells full from empty
  function [AW:0] ptr_diff;
    input [AW:0] head;
    input [AW:0] tail;
    begin
      ptr_diff = head - tail;
    end
  endfunction

  // packs one byte lane: keep in bit 0, strobe in bit 1, data above
  function [LANE_W-1:0] lane_pack;
    input [7:0] data;
    input       strobe;
    input       keep;
    begin
      lane_pack = {data, strobe, keep};
    end
  endfunction

  wire                  clr;
  wire                  wr_fire;
  wire                  rd_fire;
  wire                  out_free;
  wire                  fetch;
  wire [AW:0]           mem_used;
  wire                  mem_empty;
  wire [WW-1:0]         wr_word;
  wire [WW-1:0]         rd_word;
  wire [DW-1:0]         rd_tdata;
  wire [DATA_BYTES-1:0] rd_tstrb;
  wire [DATA_BYTES-1:0] rd_tkeep;
  wire                  rd_tlast;
  wire [DEST_W-1:0]     rd_tdest;
  wire [ID_W-1:0]       rd_tid;
  wire [USER_W-1:0]     rd_tuser;

  reg  [AW:0]           wr_ptr_q;
  reg  [AW:0]           wr_ptr_d;
  reg  [AW:0]           rd_ptr_q;
  reg  [AW:0]           rd_ptr_d;
  reg                   rd_pend_q;
  reg                   rd_pend_d;
  reg  [AW+1:0]         occ_q;
  reg  [AW+1:0]         occ_d;
  reg  [AW:0]           level_d;
  reg                   s_tready_d;
  reg                   m_tvalid_d;

  // either reset empties the queue; the global one only when built in
  assign clr       = ~rst_n | ((HAS_ARESETN != 0) & ~aresetn);
  assign wr_fire   = s_tvalid & s_tready;
  assign rd_fire   = m_tvalid & m_tready;
  assign mem_used  = ptr_diff(wr_ptr_q, rd_ptr_q);
  assign mem_empty = (mem_used == {(AW+1){1'b0}});

  // fetch when the output stage will be free and no fetch is in flight
  assign out_free  = ~m_tvalid | rd_fire;
  assign fetch     = ~mem_empty & ~rd_pend_q & out_free & ~clr;

  // byte lanes keep their order in the stored word
  genvar lane;
  generate
    for (lane = 0; lane < DATA_BYTES; lane = lane + 1) begin : g_lane
      wire [LANE_W-1:0] lane_in;
      assign lane_in = lane_pack(s_tdata[lane*8 +: 8], s_tstrb[lane], s_tkeep[lane]);
      assign wr_word[POS_LANES+lane*LANE_W +: LANE_W] = lane_in;
      assign rd_tdata[lane*8 +: 8] = rd_word[POS_LANES+lane*LANE_W+2 +: 8];
      assign rd_tstrb[lane]        = rd_word[POS_LANES+lane*LANE_W+1];
      assign rd_tkeep[lane]        = rd_word[POS_LANES+lane*LANE_W];
    end
  endgenerate

  // sideband fields sit below the lanes
  assign wr_word[POS_LAST]           = s_tlast;
  assign wr_word[POS_DEST +: DEST_W] = s_tdest;
  assign wr_word[POS_ID +: ID_W]     = s_tid;
  assign wr_word[POS_USER +: USER_W] = s_tuser;
  assign rd_tlast = rd_word[POS_LAST];
  assign rd_tdest = rd_word[POS_DEST +: DEST_W];
  assign rd_tid   = rd_word[POS_ID +: ID_W];
  assign rd_tuser = rd_word[POS_USER +: USER_W];

  // both memory styles behave alike; the style choice only steers the build
  // the memory reads only addresses written at an earlier edge
  asfifo_mem #(
    .AW (AW),
    .DW (WW)
  ) u_mem (
    .clk       (sys_clk),
    .wr_en     (wr_fire),
    .wr_addr   (wr_ptr_q[AW-1:0]),
    .wr_data   (wr_word),
    .rd_en     (fetch),
    .rd_addr   (rd_ptr_q[AW-1:0]),
    .rd_data_q (rd_word)
  );

  // next pointer values
  always @* begin
    wr_ptr_d = wr_ptr_q;
    if (wr_fire) begin
      wr_ptr_d = wr_ptr_q + PTR_ONE;
    end
  end

  always @* begin
    rd_ptr_d = rd_ptr_q;
    if (fetch) begin
      rd_ptr_d = rd_ptr_q + PTR_ONE;
    end
  end

  // a fetch puts the head word on the memory output one edge later
  always @* begin
    rd_pend_d = fetch;
  end

  // slots held: memory, word in flight and output stage
  always @* begin
    case ({wr_fire, rd_fire})
      2'b10: begin
        occ_d = occ_q + OCC_ONE;
      end
      2'b01: begin
        occ_d = occ_q - OCC_ONE;
      end
      default: begin
        occ_d = occ_q;
      end
    endcase
  end

  // ready only while the memory keeps a free slot after this edge
  always @* begin
    level_d    = ptr_diff(wr_ptr_d, rd_ptr_d);
    s_tready_d = (level_d != FULL_LEVEL);
  end

  // output stage fills from the memory and empties on the handshake
  always @* begin
    m_tvalid_d = m_tvalid;
    if (rd_pend_q) begin
      m_tvalid_d = 1'b1;
    end else if (rd_fire) begin
      m_tvalid_d = 1'b0;
    end
  end

  // pointers
  always @(posedge sys_clk) begin
    if (clr) begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // fetch in flight and slot count
  always @(posedge sys_clk) begin
    if (clr) begin
      rd_pend_q <= 1'b0;
      occ_q     <= {(AW+2){1'b0}};
    end else begin
      rd_pend_q <= rd_pend_d;
      occ_q     <= occ_d;
    end
  end

  always @(posedge sys_clk) begin
    if (clr) begin
      s_tready <= 1'b0;
    end else begin
      s_tready <= s_tready_d;
    end
  end

  always @(posedge sys_clk) begin
    if (clr) begin
      m_tvalid <= 1'b0;
    end else begin
      m_tvalid <= m_tvalid_d;
    end
  end

  // head word fields load together, only when a fetched word arrives
  always @(posedge sys_clk) begin
    if (clr) begin
      m_tdata <= {DW{1'b0}};
      m_tstrb <= {DATA_BYTES{1'b0}};
      m_tkeep <= {DATA_BYTES{1'b0}};
      m_tlast <= 1'b0;
      m_tdest <= {DEST_W{1'b0}};
      m_tid   <= {ID_W{1'b0}};
      m_tuser <= {USER_W{1'b0}};
    end else if (rd_pend_q) begin
      m_tdata <= rd_tdata;
      m_tstrb <= rd_tstrb;
      m_tkeep <= rd_tkeep;
      m_tlast <= rd_tlast;
      m_tdest <= rd_tdest;
      m_tid   <= rd_tid;
      m_tuser <= rd_tuser;
    end
  end

  // count of words held, updated at the same edge as each handshake
  always @(posedge sys_clk) begin
    if (clr) begin
      data_count <= {CW{1'b0}};
    end else if (HAS_COUNT != 0) begin
      data_count <= occ_d[CW-1:0];
    end else begin
      data_count <= {CW{1'b0}};
    end
  end
endmodule

/* verif/asfifo_props.sv */
// Purpose: port checks on the stream fifo
// Assumes: sync resets, one clock
// Notes:   bound into asfifo_top
module asfifo_props #(parameter DEPTH = 16, CW = $clog2(DEPTH)) (
  input        sys_clk,
  input        rst_n,
  input        aresetn,
  input        s_tvalid,
  input        s_tready,
  input        m_tvalid,
  input        m_tready,
  input [CW:0] data_count
);
  wire wr = s_tvalid && s_tready && aresetn;
  wire rd = m_tvalid && m_tready && aresetn;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_valid_held: assert property (m_tvalid && !m_tready && aresetn |=> m_tvalid) else $error("hold");
  a_empty_idle: assert property (data_count == 0 |-> !m_tvalid) else $error("empty");
  a_full_stall: assert property (data_count > 2 ** CW |-> !s_tready) else $error("full");
  a_count_up: assert property (wr && !rd |=> data_count == $past(data_count) + 1) else $error("up");
  a_count_down: assert property (rd && !wr |=> data_count == $past(data_count) - 1) else $error("down");
  a_count_keep: assert property (wr && rd |=> $stable(data_count)) else $error("keep");
  a_first_out: assert property (wr && data_count == 0 |-> ##[1:3] m_tvalid) else $error("late");
  a_reset_clear: assert property (!aresetn |=> data_count == 0 && !m_tvalid) else $error("clear");
  cover property (wr && rd);
  cover property (data_count > 2 ** CW);
  cover property (!aresetn && m_tvalid);
endmodule
bind asfifo_top asfifo_props #(.DEPTH(DEPTH)) u_props (.sys_clk, .rst_n, .aresetn, .s_tvalid, .s_tready,
  .m_tvalid, .m_tready, .data_count);

/* verif/asfifo_sink.sv */
// Purpose: downstream sink
// Assumes: mode 0 fast, 1 slow, 2 stall
// Notes:   ready moves just after the edge
module asfifo_sink (
  input        sys_clk,
  input  [1:0] mode,
  output logic m_tready = 1'h0
);
  timeunit 1ns / 1ns;
  always @(posedge sys_clk) m_tready <= #2 mode == 2'h0 || (mode == 2'h1 && $time % 200 < 50);
endmodule

/* verif/asfifo_tb_top.sv */
// Purpose: asfifo_top bench
// Assumes: depth 16, one data byte
// Notes:   g holds count and head word
module asfifo_tb_top;
  timeunit 1ns / 1ns;
  logic        sys_clk = 1'h0, rst_n = 1'h0, aresetn = 1'h1, s_tvalid = 1'h0;
  logic [1:0]  mode = 2'h0;
  logic [13:0] w = 14'h0, q[$];
  wire  [18:0] g;
  wire         s_tready, m_tvalid, m_tready;
  int          errors = 0, cmp_count = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  asfifo_top uut (.sys_clk, .rst_n, .aresetn, .s_tvalid, .s_tready, .s_tdata(w[13:6]), .s_tstrb(w[5]),
    .s_tkeep(w[4]), .s_tlast(w[3]), .s_tdest(w[2]), .s_tid(w[1]), .s_tuser(w[0]), .m_tvalid, .m_tready,
    .m_tdata(g[13:6]), .m_tstrb(g[5]), .m_tkeep(g[4]), .m_tlast(g[3]), .m_tdest(g[2]), .m_tid(g[1]),
    .m_tuser(g[0]), .data_count(g[18:14]));
  asfifo_sink sink (.sys_clk, .mode, .m_tready);
  task report_and_stop(int hang);
    errors += hang;
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(string n, logic [13:0] s, e);
    cmp_count++;
    errors += int'(s !== e);
    if (s !== e) $display("FAIL %s exp %h seen %h", n, e, s);
  endtask
  always @(posedge sys_clk) if (rst_n && aresetn && m_tvalid && m_tready) chk("word", g[13:0], q.pop_front());
  always @(posedge sys_clk) if (++cyc == 2000) report_and_stop(1);
  task push(int n);
    s_tvalid = 1'h1;
    for (int i = 0; i < n; i++) begin
      w = 14'(i * 5189 + n);
      @(posedge sys_clk iff s_tready) #2 q.push_back(w);
    end
    s_tvalid = 1'h0;
  endtask
  task t_stream(logic [1:0] m);
    mode = m;
    push(20);
    for (int k = 0; k < 300 && g[18:14] != 5'h0; k++) #50;
    chk("count", 14'(g[18:14]), 14'h0);
    chk("left", 14'(q.size()), 14'h0);
  endtask
  task t_fill;
    mode = 2'h2;
    push(17);
    #50 chk("full", 14'(g[18:14]), 14'h11);
    chk("ready", 14'(s_tready), 14'h0);
    aresetn = 1'h0;
    #50 aresetn = 1'h1;
    q.delete();
    mode = 2'h0;
    #100 chk("count", 14'(g[18:14]), 14'h0);
  endtask
  initial begin
    #177 rst_n = 1'h1;
    t_stream(2'h0);
    t_stream(2'h1);
    t_fill();
    report_and_stop(0);
  end
endmodule
